// file: dac_port_pkg.sv
// Purpose: Constants and types for the parallel DAC port controller.
// Assumes: One 50 MHz clock; the DAC is a clockless edge-loaded port.
// Notes: Timing counts are whole cycles of the controller clock.
package dac_port_pkg;

	localparam int          CODE_W        = 12;
	localparam int          CLK_MHZ       = 50;
	localparam int          SETUP_NS      = 40;
	localparam int          SELECT_NS     = 60;
	localparam int          IDLE_NS       = 40;
	localparam int          SETUP_CYC     = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int          SELECT_CYC    = (SELECT_NS * CLK_MHZ + 999) / 1000;
	localparam int          IDLE_CYC      = (IDLE_NS * CLK_MHZ + 999) / 1000;
	localparam int          CNT_W         = 4;
	localparam int          FIFO_DEPTH    = 8;
	localparam logic [11:0] CODE_RESET    = 12'h000;
	localparam logic [3:0]  CNT_RESET     = 4'h0;

	typedef struct packed {
		logic              rd;
		logic [CODE_W-1:0] code;
	} req_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_SELECT,
		ST_RELEASE,
		ST_GAP
	} state_t;

endpackage

// file: dac_req_fifo.sv
`timescale 1ns/1ns
// Purpose: Request FIFO with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Width and depth are parameters; depth is a power of two.
module dac_req_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Fill side.
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side.
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid_o = wr_ptr != rd_ptr;
	assign out_data_o  = mem[rd_ptr[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

endmodule // dac_req_fifo

// file: dac_port_host.sv
`timescale 1ns/1ns
// Purpose: Host controller that writes and reads back a parallel DAC code.
// Assumes: DAC pins are synchronous to REF_CLK_I; data bus is two-way.
// Notes: Requests queue in an 8-entry FIFO; each access is one select pulse.
module dac_port_host
	import dac_port_pkg::*;
(
	// Clock and reset.
	input  wire logic              REF_CLK_I,
	input  wire logic              RESETN_I,
	// Request side.
	input  wire logic              REQ_VALID_I,
	output logic                   REQ_READY_O,
	input  wire logic              REQ_RD_I,
	input  wire logic [CODE_W-1:0] REQ_CODE_I,
	// Answer side.
	output logic                   DONE_O,
	output logic                   RD_VALID_O,
	output logic      [CODE_W-1:0] RD_CODE_O,
	output logic                   BUSY_O,
	// DAC pins.
	output logic                   DAC_SEL_N_O,
	output logic                   DAC_RD_WR_N_O,
	output logic      [CODE_W-1:0] DAC_DATA_O,
	output logic                   DAC_DATA_OE_N_O,
	input  wire logic [CODE_W-1:0] DAC_DATA_I
);

	//--------------------------------------------------------------
	// Request queue
	//--------------------------------------------------------------
	req_t   fifo_in;
	req_t   cur;
	logic   fifo_valid;
	logic   fifo_ready;
	logic   fifo_take;
	logic   fifo_push;
	state_t state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] fill;
	logic [CNT_W-1:0] next_fill;

	assign fifo_in   = '{rd: REQ_RD_I, code: REQ_CODE_I};
	assign fifo_take = (state == ST_IDLE) && fifo_valid;
	assign fifo_push = REQ_VALID_I && REQ_READY_O;
	assign next_fill = fill + CNT_W'(fifo_push) - CNT_W'(fifo_take);

	dac_req_fifo #(
		.WIDTH ($bits(req_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (REF_CLK_I),
		.rst_n_i     (RESETN_I),
		.in_valid_i  (fifo_push),
		.in_ready_o  (fifo_ready),
		.in_data_i   (fifo_in),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_take),
		.out_data_o  (cur)
	);

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			fill        <= CNT_RESET;
			REQ_READY_O <= 1'b0;
		end else begin
			fill        <= next_fill;
			REQ_READY_O <= next_fill != CNT_W'(FIFO_DEPTH);
		end
	end

	//--------------------------------------------------------------
	// Access sequencer
	//--------------------------------------------------------------
	function automatic logic [CNT_W-1:0] cyc(input int n);
		return CNT_W'(n - 1);
	endfunction

	req_t act;

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state <= ST_IDLE;
			cnt   <= CNT_RESET;
			act   <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (fifo_valid) begin
						act   <= cur;
						cnt   <= cyc(SETUP_CYC);
						state <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					if (cnt == CNT_RESET) begin
						cnt   <= cyc(SELECT_CYC);
						state <= ST_SELECT;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_SELECT: begin
					if (cnt == CNT_RESET) begin
						state <= ST_RELEASE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				ST_RELEASE: begin
					cnt   <= cyc(IDLE_CYC);
					state <= ST_GAP;
				end
				ST_GAP: begin
					if (cnt == CNT_RESET) begin
						state <= ST_IDLE;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
			endcase
		end
	end

	//--------------------------------------------------------------
	// Pin drive
	//--------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			DAC_SEL_N_O     <= 1'b1;
			DAC_RD_WR_N_O   <= 1'b1;
			DAC_DATA_O      <= CODE_RESET;
			DAC_DATA_OE_N_O <= 1'b1;
		end else begin
			if (state == ST_SETUP && cnt == CNT_RESET) begin
				DAC_SEL_N_O <= 1'b0;
			end else if (state == ST_SELECT && cnt == CNT_RESET) begin
				DAC_SEL_N_O <= 1'b1;
			end
			if (state == ST_IDLE && fifo_valid) begin
				DAC_RD_WR_N_O   <= cur.rd;
				DAC_DATA_O      <= cur.code;
				DAC_DATA_OE_N_O <= cur.rd;
			end else if (state == ST_GAP && cnt == CNT_RESET) begin
				DAC_RD_WR_N_O   <= 1'b1;
				DAC_DATA_OE_N_O <= 1'b1;
			end
		end
	end

	//--------------------------------------------------------------
	// Answers
	//--------------------------------------------------------------
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			DONE_O     <= 1'b0;
			RD_VALID_O <= 1'b0;
			RD_CODE_O  <= CODE_RESET;
			BUSY_O     <= 1'b0;
		end else begin
			DONE_O     <= state == ST_RELEASE;
			RD_VALID_O <= 1'b0;
			BUSY_O     <= state != ST_IDLE || fifo_valid;
			if (state == ST_SELECT && cnt == CNT_RESET && act.rd) begin
				RD_CODE_O  <= DAC_DATA_I;
				RD_VALID_O <= 1'b1;
			end
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	sel_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		$fell(DAC_SEL_N_O) |-> !DAC_SEL_N_O [*3] ##1 DAC_SEL_N_O)
		else $error("Select pulse length wrong.");
	write_drive_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		(!DAC_SEL_N_O && !DAC_RD_WR_N_O) |-> !DAC_DATA_OE_N_O)
		else $error("Write without bus drive.");
	read_release_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		DAC_RD_WR_N_O |-> DAC_DATA_OE_N_O)
		else $error("Bus driven during read.");
	rw_stable_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!DAC_SEL_N_O |-> $stable(DAC_RD_WR_N_O) && $stable(DAC_DATA_O))
		else $error("Control changed while selected.");
	read_sample_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		RD_VALID_O |-> $past(DAC_RD_WR_N_O) && $past(DAC_SEL_N_O, 2) == 1'b0)
		else $error("Read sampled outside select.");
	done_after_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		$rose(DAC_SEL_N_O) |-> ##1 DONE_O)
		else $error("Done missing after access.");
	setup_first_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		$fell(DAC_SEL_N_O) |-> $past(DAC_SEL_N_O, 2))
		else $error("Select fell without setup.");
	gap_min_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		$rose(DAC_SEL_N_O) |-> DAC_SEL_N_O [*4])
		else $error("Select high gap too short.");
	ready_safe_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		REQ_READY_O |-> fifo_ready)
		else $error("Ready shown while queue full.");
	fill_bound_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		fill <= CNT_W'(FIFO_DEPTH))
		else $error("Queue count out of range.");
	done_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		DONE_O |=> !DONE_O)
		else $error("Done longer than one cycle.");
	read_code_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		RD_VALID_O |-> RD_CODE_O == $past(DAC_DATA_I))
		else $error("Read code not taken from bus.");
	idle_release_a: assert property (@(posedge REF_CLK_I) disable iff (!RESETN_I)
		!BUSY_O |-> DAC_DATA_OE_N_O && DAC_SEL_N_O)
		else $error("Pins active while idle.");

	//--------------------------------------------------------------
	// Cover points
	//--------------------------------------------------------------
	write_cov_c: cover property (@(posedge REF_CLK_I) $rose(DAC_SEL_N_O) && !DAC_RD_WR_N_O);
	read_cov_c: cover property (@(posedge REF_CLK_I) RD_VALID_O);
	full_cov_c: cover property (@(posedge REF_CLK_I) !REQ_READY_O && BUSY_O);
	queue_cov_c: cover property (@(posedge REF_CLK_I) DONE_O && fifo_valid);

endmodule // dac_port_host

// file: dac_port_model.sv
`timescale 1ns/1ns
// Purpose: Behavioural parallel DAC port facing the host controller.
// Assumes: Edge-loaded latches, no clock, no pull on the data lines.
// Notes: Released lines show the inverse of the code latched at the last read select.
module dac_port_model
	import dac_port_pkg::*;
(
	// Pins.
	input  wire logic              sel_n_i,
	input  wire logic              rd_wr_n_i,
	input  wire logic [CODE_W-1:0] data_i,
	output logic      [CODE_W-1:0] data_o,
	output logic                   drive_o,
	// Observation.
	output logic      [CODE_W-1:0] dac_reg_o,
	output int                     n_wr_o
);
	logic [CODE_W-1:0] in_reg = 12'h000;
	initial begin
		dac_reg_o = 12'h000;
		n_wr_o = 0;
	end
	always @(posedge sel_n_i) begin
		if (rd_wr_n_i === 1'b0) begin
			dac_reg_o <= data_i;
			n_wr_o <= n_wr_o + 1;
		end
	end
	always @(negedge sel_n_i) begin
		if (rd_wr_n_i === 1'b1) in_reg <= dac_reg_o;
	end
	assign drive_o = (sel_n_i === 1'b0) && (rd_wr_n_i === 1'b1);
	assign data_o = drive_o ? in_reg : ~in_reg;
endmodule // dac_port_model

// file: tb_dac_port_host.sv
`timescale 1ns/1ns
// Purpose: Self-checking bench for the parallel DAC host controller.
// Assumes: Inputs change at the falling clock edge.
// Notes: The bus level is resolved from the host output enable alone.
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_dac_port_host;
	import dac_port_pkg::*;
	logic              ref_clk = 1'b0;
	logic              resetn = 1'b0;
	logic              req_valid = 1'b0;
	logic              req_rd = 1'b0;
	logic [CODE_W-1:0] req_code = 12'h000;
	logic              req_ready, done, rd_valid, busy, sel_n, rd_wr_n, oe_n, drive, saw_full;
	logic [CODE_W-1:0] rd_code, host_data, model_data, bus, dac_reg;
	int                n_wr, n_mismatch = 0, total_checks = 0, n_rise = 0, n_done = 0;
	always #10 ref_clk = ~ref_clk;
	assign bus = oe_n ? model_data : host_data;
	dac_port_host DUT (.REF_CLK_I(ref_clk), .RESETN_I(resetn), .REQ_VALID_I(req_valid),
		.REQ_READY_O(req_ready), .REQ_RD_I(req_rd), .REQ_CODE_I(req_code), .DONE_O(done),
		.RD_VALID_O(rd_valid), .RD_CODE_O(rd_code), .BUSY_O(busy), .DAC_SEL_N_O(sel_n),
		.DAC_RD_WR_N_O(rd_wr_n), .DAC_DATA_O(host_data), .DAC_DATA_OE_N_O(oe_n),
		.DAC_DATA_I(bus));
	dac_port_model MODEL (.sel_n_i(sel_n), .rd_wr_n_i(rd_wr_n), .data_i(bus),
		.data_o(model_data), .drive_o(drive), .dac_reg_o(dac_reg), .n_wr_o(n_wr));
	// --------------------------------------------------------------
	// Monitors and shared tasks.
	// --------------------------------------------------------------
	always @(posedge sel_n) if (resetn) n_rise++;
	always @(negedge ref_clk) begin
		if (done === 1'b1) n_done++;
		if (resetn) `CHK("bus clash", 1'b0, !oe_n && drive)
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic fail();
		n_mismatch++;
		$display("BAD wait exp 1 got 0");
		give_verdict();
	endtask
	task automatic push(input logic rd, input logic [CODE_W-1:0] code);
		int i;
		req_valid = 1'b1;
		req_rd = rd;
		req_code = code;
		for (i = 0; i < 300 && req_ready !== 1'b1; i++) begin
			saw_full = 1'b1;
			@(negedge ref_clk);
		end
		if (i == 300) fail();
		@(negedge ref_clk);
	endtask
	task automatic wait_on(input int rd);
		int i;
		req_valid = 1'b0;
		repeat (2) @(negedge ref_clk);
		for (i = 0; i < 300 && (rd ? rd_valid : busy) !== rd[0]; i++) @(negedge ref_clk);
		if (i == 300) fail();
	endtask
	// --------------------------------------------------------------
	// Scenarios.
	// --------------------------------------------------------------
	task automatic t_reset();
		`CHK("sel", 1'b1, sel_n)
		`CHK("oe", 1'b1, oe_n)
		`CHK("ready", 1'b0, req_ready)
	endtask
	task automatic t_write_read();
		logic [CODE_W-1:0] codes [4] = '{12'h0A5, 12'h2C3, 12'hFFF, 12'h000};
		int r;
		foreach (codes[k]) begin
			r = n_rise;
			push(1'b0, codes[k]);
			wait_on(0);
			`CHK("dac reg", codes[k], dac_reg)
			`CHK("edges", r + 1, n_rise)
			push(1'b1, 12'h000);
			wait_on(1);
			`CHK("rd code", codes[k], rd_code)
			wait_on(0);
		end
	endtask
	task automatic t_burst();
		int w;
		int d;
		w = n_wr;
		d = n_done;
		saw_full = 1'b0;
		for (int k = 0; k < 10; k++) push(1'b0, 12'h100 + 12'(k));
		push(1'b1, 12'h000);
		wait_on(1);
		`CHK("burst rd", 12'h109, rd_code)
		wait_on(0);
		`CHK("burst wr", w + 10, n_wr)
		`CHK("burst done", d + 11, n_done)
		`CHK("fifo full", 1'b1, saw_full)
	endtask
	initial begin
		repeat (20) @(negedge ref_clk);
		t_reset();
		resetn = 1'b1;
		repeat (2) @(negedge ref_clk);
		t_write_read();
		t_burst();
		give_verdict();
	end
endmodule // tb_dac_port_host
